// file: rtl/modem_seq_map.vh
// constants, register map and timing counts of the modem power and sleep sequencer
// Functional notes
// - hold power key low 500 ms to start
// - release power key only after status high; the sequencer also releases it, status low, when the S_ON_WAIT timeout expires
// - supply stable 30 ms before power key
// - off needs 800 ms low, then release
// - keep power key high after power-down command
// - cut supply only after completed turn-off
// - drive rf_disable_n low for airplane mode
// - uart sleep needs enable and terminal_ready high
// - terminal_ready low wakes the module
// - usb sleep needs enable, ready high, suspend
// - host usb traffic wakes the module
// - no suspend: cut usb power to sleep
`ifndef MODEM_SEQ_MAP_VH
`define MODEM_SEQ_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STAT 8'h08
`define REG_TOUT 8'h0C

// ****************************************
// field positions
// ****************************************
`define CTRL_RF_OFF 0
`define CTRL_SLEEP_ALLOW 1
`define CTRL_USB_SUSPEND 2
`define CTRL_USB_PWR_CUT 3
`define CTRL_SUPPLY_EN 4
`define CMD_ON 0
`define CMD_OFF 1
`define CMD_SW_DOWN 2
`define CMD_CLR 3

// ****************************************
// reset values
// ****************************************
`define CTRL_RST 32'h0000_0000
`define TOUT_RST 32'h0026_25A0

// ****************************************
// timing in milliseconds and clock
// ****************************************
`define CLK_KHZ 125000
`define ON_MS 500
`define OFF_MS 800
`define SUPPLY_MS 30

`endif

// file: rtl/ms_ms_timer.v
// down counter used for millisecond waits
`timescale 1ns/100ps
module ms_timer #(
   parameter W = 32
) (
   input wire clk,
   input wire rstn,
   input wire load,
   input wire [W-1:0] value,
   output reg done_r
);
   reg [W-1:0] cnt_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= {W{1'b0}};
         done_r <= 1'b0;
      end else if (load) begin
         cnt_r <= value;
         done_r <= 1'b0;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
      end else begin
         done_r <= 1'b1;
      end
   end
endmodule // ms_timer

// file: rtl/modem_power_sleep_sequencer.v
// host-side sequencer driving a cellular module's power, airplane and sleep pins
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "modem_seq_map.vh"
module modem_power_sleep_sequencer #(
   parameter [31:0] ON_CYC = `ON_MS * `CLK_KHZ,
   parameter [31:0] OFF_CYC = `OFF_MS * `CLK_KHZ,
   parameter [31:0] SUPPLY_CYC = `SUPPLY_MS * `CLK_KHZ
) (
   input wire clk,
   input wire rstn,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // module pins
   output reg power_key_o,
   output reg power_key_oe_n,
   input wire status_in,
   output reg rf_disable_n_o,
   output reg rf_disable_n_oe_n,
   output reg terminal_ready_out,
   input wire ring_indicator_in,
   output reg supply_en_r,
   output reg usb_vbus_en_r,
   output reg usb_suspend_r
);
   // ****************************************
   // states
   // ****************************************
   localparam [2:0] S_OFF = 3'd0;
   localparam [2:0] S_SETTLE = 3'd1;
   localparam [2:0] S_ON_HOLD = 3'd2;
   localparam [2:0] S_ON_WAIT = 3'd3;
   localparam [2:0] S_RUN = 3'd4;
   localparam [2:0] S_OFF_HOLD = 3'd5;
   localparam [2:0] S_DOWN = 3'd6;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [31:0] ctrl_r;
   reg [31:0] tout_r;
   reg fail_r;
   reg ring_seen_r;
   reg sw_down_r;
   reg status_s1_r;
   reg status_s2_r;
   reg ring_s1_r;
   reg ring_s2_r;
   reg ring_d_r;
   reg tmr_load;
   reg [31:0] tmr_val;
   wire tmr_done;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg aw_have_r;
   reg w_have_r;
   reg cmd_on;
   reg cmd_off;
   reg cmd_sw;
   reg cmd_clr;
   wire wr_go;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   ms_timer #(.W(32)) i_ms_timer (
      .clk(clk),
      .rstn(rstn),
      .load(tmr_load),
      .value(tmr_val),
      .done_r(tmr_done)
   );

   // ****************************************
   // pin synchronisers
   // ****************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_s1_r <= 1'b0;
         status_s2_r <= 1'b0;
         ring_s1_r <= 1'b1;
         ring_s2_r <= 1'b1;
         ring_d_r <= 1'b1;
      end else begin
         status_s1_r <= status_in;
         status_s2_r <= status_s1_r;
         ring_s1_r <= ring_indicator_in;
         ring_s2_r <= ring_s1_r;
         ring_d_r <= ring_s2_r;
      end
   end

   // ****************************************
   // axi4-lite write
   // ****************************************
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         ctrl_r <= `CTRL_RST;
         tout_r <= `TOUT_RST;
         cmd_on <= 1'b0;
         cmd_off <= 1'b0;
         cmd_sw <= 1'b0;
         cmd_clr <= 1'b0;
      end else begin
         cmd_on <= 1'b0;
         cmd_off <= 1'b0;
         cmd_sw <= 1'b0;
         cmd_clr <= 1'b0;
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (awaddr_r)
               `REG_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
               `REG_TOUT: tout_r <= merge(tout_r, wdata_r, wstrb_r);
               `REG_CMD: begin
                  if (wstrb_r[0]) begin
                     cmd_on <= wdata_r[`CMD_ON];
                     cmd_off <= wdata_r[`CMD_OFF];
                     cmd_sw <= wdata_r[`CMD_SW_DOWN];
                     cmd_clr <= wdata_r[`CMD_CLR];
                  end
               end
               `REG_STAT: s_axi_bresp <= 2'b10;
               default: s_axi_bresp <= 2'b10;
            endcase
         end
      end
   end

   // ****************************************
   // axi4-lite read
   // ****************************************
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `REG_CTRL: s_axi_rdata <= ctrl_r;
               `REG_TOUT: s_axi_rdata <= tout_r;
               `REG_CMD: s_axi_rdata <= 32'h0000_0000;
               `REG_STAT: s_axi_rdata <= {24'h00_0000, !ring_s2_r, ring_seen_r,
                  sw_down_r, fail_r, status_s2_r, state_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
      end
   end

   // ****************************************
   // power sequence
   // ****************************************
   always @* begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      tmr_val = 32'h0000_0000;
      case (state_r)
         S_OFF: begin
            if (cmd_on && ctrl_r[`CTRL_SUPPLY_EN]) begin
               state_nxt = S_SETTLE;
               tmr_load = 1'b1;
               tmr_val = SUPPLY_CYC;
            end
         end
         S_SETTLE: begin
            if (tmr_done && !tmr_load) begin
               state_nxt = S_ON_HOLD;
               tmr_load = 1'b1;
               tmr_val = ON_CYC;
            end
         end
         S_ON_HOLD: begin
            if (tmr_done) begin
               state_nxt = S_ON_WAIT;
               tmr_load = 1'b1;
               tmr_val = tout_r;
            end
         end
         S_ON_WAIT: begin
            if (status_s2_r)
               state_nxt = S_RUN;
            else if (tmr_done)
               state_nxt = S_OFF;
         end
         S_RUN: begin
            if (cmd_off) begin
               state_nxt = S_OFF_HOLD;
               tmr_load = 1'b1;
               tmr_val = OFF_CYC;
            end else if (cmd_sw)
               state_nxt = S_DOWN;
         end
         S_OFF_HOLD: begin
            if (tmr_done)
               state_nxt = S_DOWN;
         end
         S_DOWN: begin
            if (!status_s2_r)
               state_nxt = S_OFF;
         end
         default: state_nxt = S_OFF;
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= S_OFF;
         fail_r <= 1'b0;
         sw_down_r <= 1'b0;
         ring_seen_r <= 1'b0;
         power_key_o <= 1'b0;
         power_key_oe_n <= 1'b1;
         rf_disable_n_o <= 1'b0;
         rf_disable_n_oe_n <= 1'b1;
         terminal_ready_out <= 1'b0;
         supply_en_r <= 1'b0;
         usb_vbus_en_r <= 1'b1;
         usb_suspend_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == S_ON_WAIT && !status_s2_r && tmr_done)
            fail_r <= 1'b1;
         else if (cmd_clr)
            fail_r <= 1'b0;
         if (state_r == S_RUN && cmd_sw)
            sw_down_r <= 1'b1;
         else if (cmd_clr)
            sw_down_r <= 1'b0;
         // event beats clear; ring indicator pulses low
         if (ring_d_r && !ring_s2_r)
            ring_seen_r <= 1'b1;
         else if (cmd_clr)
            ring_seen_r <= 1'b0;
         // open-drain key: driven low only while holding, else released high
         power_key_oe_n <= !(state_nxt == S_ON_HOLD || state_nxt == S_ON_WAIT ||
            state_nxt == S_OFF_HOLD);
         // held through the settle wait too, so the key never meets a fresh supply
         supply_en_r <= ctrl_r[`CTRL_SUPPLY_EN] || (state_r != S_OFF);
         rf_disable_n_oe_n <= !ctrl_r[`CTRL_RF_OFF];
         // high lets the module sleep, low wakes it
         terminal_ready_out <= ctrl_r[`CTRL_SLEEP_ALLOW] && !ring_seen_r;
         usb_suspend_r <= ctrl_r[`CTRL_USB_SUSPEND] && !ring_seen_r;
         usb_vbus_en_r <= !ctrl_r[`CTRL_USB_PWR_CUT];
      end
   end
endmodule // modem_power_sleep_sequencer

// file: tb/seq_props.sv
// assertion checker for the sequencer's module-side pins
`timescale 1ns/100ps
module seq_props #(
   parameter [31:0] ON_CYC = 20,
   parameter [31:0] OFF_CYC = 30,
   parameter [31:0] SUPPLY_CYC = 10
) (
   input wire clk,
   input wire rstn,
   input wire power_key_o,
   input wire power_key_oe_n,
   input wire status_in,
   input wire rf_disable_n_o,
   input wire rf_disable_n_oe_n,
   input wire terminal_ready_out,
   input wire ring_indicator_in,
   input wire supply_en_r,
   input wire usb_suspend_r
);
   reg [31:0] low_cnt;
   reg [31:0] sup_cnt;
   reg off_r;
   // a press that starts while status is high is a turn-off press
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_cnt <= 32'h0000_0000;
         sup_cnt <= 32'h0000_0000;
         off_r <= 1'b0;
      end else begin
         low_cnt <= power_key_oe_n ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
         sup_cnt <= supply_en_r ? sup_cnt + 32'h0000_0001 : 32'h0000_0000;
         if (!power_key_oe_n && low_cnt == 32'h0000_0000) begin
            off_r <= status_in;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   key_supply_a: assert property (!supply_en_r |-> power_key_oe_n)
      else $error("key pressed with supply off");
   supply_settle_a: assert property ($fell(power_key_oe_n) |-> sup_cnt >= SUPPLY_CYC)
      else $error("key pressed before supply settled");
   on_press_a: assert property ($rose(power_key_oe_n) && !off_r |-> low_cnt >= ON_CYC)
      else $error("turn-on press too short");
   off_press_a: assert property ($rose(power_key_oe_n) && off_r |-> low_cnt >= OFF_CYC)
      else $error("turn-off press too short");
   key_drain_a: assert property (!power_key_oe_n |-> !power_key_o)
      else $error("power key driven high");
   rf_drain_a: assert property (!rf_disable_n_oe_n |-> !rf_disable_n_o)
      else $error("rf disable driven high");
   ring_ready_a: assert property ($fell(ring_indicator_in) |-> ##[1:6] !terminal_ready_out)
      else $error("ring did not drop terminal ready");
   ring_suspend_a: assert property ($fell(ring_indicator_in) |-> ##[1:6] !usb_suspend_r)
      else $error("ring did not end usb suspend");
endmodule // seq_props

bind modem_power_sleep_sequencer seq_props #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC),
   .SUPPLY_CYC(SUPPLY_CYC)) i_seq_props (.clk(clk), .rstn(rstn), .power_key_o(power_key_o),
   .power_key_oe_n(power_key_oe_n), .status_in(status_in), .rf_disable_n_o(rf_disable_n_o),
   .rf_disable_n_oe_n(rf_disable_n_oe_n), .terminal_ready_out(terminal_ready_out),
   .ring_indicator_in(ring_indicator_in), .supply_en_r(supply_en_r),
   .usb_suspend_r(usb_suspend_r));

// file: tb/modem_model.sv
// behavioural cellular module seen from its power, airplane and sleep pins
`timescale 1ns/100ps
module modem_model #(
   parameter ON_T = 18,
   parameter OFF_T = 28
) (
   input wire clk,
   input wire power_key,
   input wire supply,
   input wire rf_disable_n,
   input wire terminal_ready,
   input wire vbus,
   input wire usb_suspend,
   input wire sleep_en,
   input wire urc,
   input wire sw_down,
   input wire dead,
   output reg status = 1'b0,
   output reg ring_n = 1'b1,
   output wire rf_on,
   output wire asleep
);
   reg [7:0] cnt = 8'h00;
   reg on = 1'b0;
   // supply loss clears everything, so a cut mid-run is visible as a dead module
   always @(posedge clk) begin
      if (!supply) begin
         on <= 1'b0;
         cnt <= 8'h00;
      end else begin
         cnt <= power_key ? 8'h00 : cnt + 8'h01;
         if (!on && !power_key && cnt >= ON_T && !dead) on <= 1'b1;
         if (on && power_key && cnt >= OFF_T) on <= 1'b0;
         if (sw_down) on <= 1'b0;
      end
      status <= on;
      // this host lacks remote wakeup, so results always go out on the ring pin
      ring_n <= !(on && urc);
   end
   assign rf_on = on && rf_disable_n;
   assign asleep = on && sleep_en && terminal_ready && (usb_suspend || !vbus);
endmodule // modem_model

// file: tb/tb_top.sv
// self-checking bench for the modem power and sleep sequencer
`timescale 1ns/100ps
`include "modem_seq_map.vh"
module tb_top;
   reg clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   reg [7:0] awa = 8'h00, ara = 8'h00;
   reg [31:0] wd = 32'h0000_0000, rv;
   reg [1:0] rr;
   reg sleep_en = 1'b0, urc = 1'b0, swd = 1'b0, dead = 1'b0;
   wire awr, wr_r, bv, arr, rvd, pk_o, pk_oe, rf_o, rf_oe, tr, sup, vbus, susp, st, ring_n;
   wire rf_on, asleep;
   wire [1:0] br, rs;
   wire [31:0] rd_d;
   integer err_total = 0, tests_run = 0, cyc = 0;
   // both lines have pull-ups, so a released pin reads high
   wire pkey = pk_oe ? 1'b1 : pk_o;
   wire rfdis = rf_oe ? 1'b1 : rf_o;
   always #4 clk = ~clk;
   modem_power_sleep_sequencer #(.ON_CYC(20), .OFF_CYC(30), .SUPPLY_CYC(10))
      i_modem_power_sleep_sequencer (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd_d), .s_axi_rresp(rs), .s_axi_rvalid(rvd), .s_axi_rready(rre),
      .power_key_o(pk_o), .power_key_oe_n(pk_oe), .status_in(st), .rf_disable_n_o(rf_o),
      .rf_disable_n_oe_n(rf_oe), .terminal_ready_out(tr), .ring_indicator_in(ring_n),
      .supply_en_r(sup), .usb_vbus_en_r(vbus), .usb_suspend_r(susp));
   modem_model i_modem_model (.clk(clk), .power_key(pkey), .supply(sup), .rf_disable_n(rfdis),
      .terminal_ready(tr), .vbus(vbus), .usb_suspend(susp), .sleep_en(sleep_en), .urc(urc),
      .sw_down(swd), .dead(dead), .status(st), .ring_n(ring_n), .rf_on(rf_on), .asleep(asleep));
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task conclude;
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // settle two edges after the response so registered pins have landed
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (!bv);
      bre <= 1'b0; rr = br;
      repeat (2) @(posedge clk);
   endtask
   task rd(input [7:0] a);
      @(posedge clk);
      ara <= a; arv <= 1'b1; rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rvd);
      rre <= 1'b0; rv = rd_d; rr = rs;
   endtask
   task ring;
      urc <= 1'b1;
      repeat (8) @(posedge clk);
      urc <= 1'b0;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc > 20000) begin
         err_total = err_total + 1;
         conclude;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      chk({pk_oe, sup, vbus, tr}, 4'b1010, "reset_pins");
      rstn <= 1'b1;
      rd(`REG_CTRL); chk(rv, `CTRL_RST, "ctrl_reset");
      rd(`REG_TOUT); chk(rv, `TOUT_RST, "tout_reset");
      rd(8'h10); chk(rr, 2'b10, "unmapped_resp");
      chk(rv, 32'h0000_0000, "unmapped_data");
      wr(`REG_STAT, 32'h0000_00FF); chk(rr, 2'b10, "stat_write");
      wr(`REG_CTRL, 32'h0000_0010); wr(`REG_CMD, 32'h0000_0001);
      wait (st === 1'b1); chk(pk_oe, 1'b0, "key_held");
      wait (pk_oe === 1'b1); rd(`REG_STAT); chk(rv[4:3], 2'b01, "on_state");
      wr(`REG_CTRL, 32'h0000_0011); chk({rf_oe, rf_on}, 2'b00, "airplane");
      wr(`REG_CTRL, 32'h0000_0010); chk(rf_on, 1'b1, "rf_back");
      sleep_en <= 1'b1;
      wr(`REG_CTRL, 32'h0000_0012); chk(tr, 1'b1, "uart_sleep");
      ring; chk(tr, 1'b0, "ring_wake");
      rd(`REG_STAT); chk(rv[6], 1'b1, "ring_seen");
      wr(`REG_CMD, 32'h0000_0008); chk(tr, 1'b1, "ring_clear");
      wr(`REG_CTRL, 32'h0000_0016); chk({susp, asleep}, 2'b11, "usb_sleep");
      ring; chk(susp, 1'b0, "usb_ring");
      wr(`REG_CMD, 32'h0000_0008);
      wr(`REG_CTRL, 32'h0000_001A); chk({vbus, asleep}, 2'b01, "vbus_cut");
      wr(`REG_CTRL, 32'h0000_0010); chk({vbus, asleep}, 2'b10, "vbus_back");
      wr(`REG_CMD, 32'h0000_0002);
      repeat (10) @(posedge clk);
      chk({pk_oe, st}, 2'b01, "off_hold");
      wait (st === 1'b0); chk(pk_oe, 1'b1, "off_release");
      wr(`REG_CMD, 32'h0000_0001);
      wait (pk_oe === 1'b0); wait (pk_oe === 1'b1);
      swd <= 1'b1;
      wr(`REG_CMD, 32'h0000_0004);
      swd <= 1'b0;
      repeat (40) @(posedge clk);
      rd(`REG_STAT); chk({pk_oe, rv[5], st}, 3'b110, "sw_down");
      wr(`REG_CTRL, 32'h0000_0000); chk(sup, 1'b0, "supply_off");
      dead <= 1'b1;
      wr(`REG_TOUT, 32'h0000_0028); wr(`REG_CTRL, 32'h0000_0010); wr(`REG_CMD, 32'h0000_0001);
      wait (pk_oe === 1'b0); wait (pk_oe === 1'b1);
      rd(`REG_STAT); chk(rv[4:3], 2'b10, "on_timeout");
      conclude;
   end
endmodule // tb_top
